// ==== verilog/spc_defines.vh ====
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// Serial frame: read flag, 7-bit address, 8-bit data, MSB first
`define SPC_HDR_BITS      4'h8
`define SPC_FRAME_BITS    5'h10
`define SPC_CNT_W         5
`define SPC_ADDR_W        7
`define SPC_DATA_W        8
`define SPC_RW_BIT        7
`define SPC_FRM_MSB       15
`define SPC_ADDR_MSB      14
`define SPC_ADDR_LSB      8

// Register addresses
`define SPC_ADDR_CTRL     7'h00
`define SPC_ADDR_POWER    7'h01
`define SPC_ADDR_STATUS   7'h02

// Control register fields
`define SPC_CTRL_PD_BIT   0
`define SPC_CTRL_4W_BIT   1

// Output power register fields
`define SPC_PWR1_LSB      0
`define SPC_PWR2_LSB      4
`define SPC_PWR_W         4

// Reset values
`define SPC_CTRL_RST      8'h00
`define SPC_POWER_RST     8'hFF

// Synchroniser lanes
`define SPC_SYNC_W        7
`define SPC_LANE_CE       0
`define SPC_LANE_SEL      1
`define SPC_LANE_SCLK     2
`define SPC_LANE_SDIO     3
`define SPC_LANE_EN1      4
`define SPC_LANE_EN2      5
`define SPC_LANE_LOCK     6

`endif

// ==== verilog/spc_sync.v ====
`timescale 1ns/100ps
`default_nettype none

module spc_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk_in,
  input  wire             resetn_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // spc_sync

`default_nettype wire

// ==== verilog/spc_pin_ctrl.v ====
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.vh"

module spc_pin_ctrl (
  input  wire       core_clk_in,
  input  wire       resetn_in,
  input  wire       chip_enable_in,
  input  wire       out1_buffer_enable_in,
  input  wire       out2_buffer_enable_in,
  input  wire       pll_locked_in,
  input  wire       select_n_in,
  input  wire       sclk_in,
  input  wire       sdio_in,
  output wire       sdio_out,
  output wire       sdio_oe_out,
  output wire       read_data_out,
  output wire       read_data_oe_out,
  output wire       lock_indicator_out,
  output wire       device_active_out,
  output wire       global_power_down_out,
  output wire       out1_active_out,
  output wire       out2_active_out,
  output wire [3:0] out1_power_out,
  output wire [3:0] out2_power_out
);

  wire [`SPC_SYNC_W-1:0] pins_s;
  wire                   ce_s;
  wire                   sel_s;
  wire                   sclk_s;
  wire                   sdio_s;

  reg                    sclk_prev_q;
  reg                    sel_prev_q;
  reg [`SPC_CNT_W-1:0]   bit_cnt_q;
  reg [`SPC_FRM_MSB:0]   shift_q;
  reg [`SPC_DATA_W-1:0]  tx_q;
  reg                    rd_phase_q;
  reg                    dout_q;
  reg                    drive_q;
  reg [`SPC_DATA_W-1:0]  ctrl_q;
  reg [`SPC_DATA_W-1:0]  power_q;
  reg                    active_q;
  reg                    out1_q;
  reg                    out2_q;
  reg                    lock_q;

  wire                   sclk_rise;
  wire                   sclk_fall;
  wire                   in_burst;
  wire                   burst_end;
  wire [`SPC_FRM_MSB:0]  shift_d;
  wire [`SPC_CNT_W-1:0]  bit_cnt_d;
  wire                   four_wire;
  wire                   pd_bit;
  wire                   frame_is_rd;
  wire [`SPC_ADDR_W-1:0] frame_addr;

  // Select lane is inverted so its flop reset value reads as an idle bus
  spc_sync #(
    .WIDTH(`SPC_SYNC_W)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .resetn_in  (resetn_in),
    .async_in   ({pll_locked_in, out2_buffer_enable_in, out1_buffer_enable_in,
                  sdio_in, sclk_in, ~select_n_in, chip_enable_in}),
    .sync_out   (pins_s)
  );

  assign ce_s   = pins_s[`SPC_LANE_CE];
  assign sel_s  = ~pins_s[`SPC_LANE_SEL];
  assign sclk_s = pins_s[`SPC_LANE_SCLK];
  assign sdio_s = pins_s[`SPC_LANE_SDIO];

  // Serial clock only runs inside bursts, so edges are qualified by select
  assign in_burst  = ce_s & ~sel_s;
  assign sclk_rise = in_burst & sclk_s & ~sclk_prev_q;
  assign sclk_fall = in_burst & ~sclk_s & sclk_prev_q;
  assign burst_end = sel_s & ~sel_prev_q;
  assign shift_d   = {shift_q[`SPC_FRM_MSB-1:0], sdio_s};
  assign bit_cnt_d = bit_cnt_q + 5'h01;

  // Fields of a complete frame
  assign frame_is_rd = shift_d[`SPC_FRM_MSB];
  assign frame_addr  = shift_d[`SPC_ADDR_MSB:`SPC_ADDR_LSB];

  assign four_wire = ctrl_q[`SPC_CTRL_4W_BIT];
  assign pd_bit    = ctrl_q[`SPC_CTRL_PD_BIT];

  // Read-back value of one register
  function [`SPC_DATA_W-1:0] rd_mux;
    input [`SPC_ADDR_W-1:0] addr;
    input [`SPC_DATA_W-1:0] ctrl;
    input [`SPC_DATA_W-1:0] power;
    input [`SPC_DATA_W-1:0] status;
    begin
      case (addr)
        `SPC_ADDR_CTRL:   rd_mux = ctrl;
        `SPC_ADDR_POWER:  rd_mux = power;
        `SPC_ADDR_STATUS: rd_mux = status;
        default:          rd_mux = 8'h00;
      endcase
    end
  endfunction

  // Chip enable high and power-down bit clear
  function run_gate;
    input ce;
    input pd;
    begin
      run_gate = ce & ~pd;
    end
  endfunction

  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_prev_q <= 1'b0;
      sel_prev_q  <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      sel_prev_q  <= sel_s;
    end
  end

  // Serial shifter and register file
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_cnt_q  <= 5'h00;
      shift_q    <= 16'h0000;
      tx_q       <= 8'h00;
      rd_phase_q <= 1'b0;
      dout_q     <= 1'b0;
      drive_q    <= 1'b0;
      ctrl_q     <= `SPC_CTRL_RST;
      power_q    <= `SPC_POWER_RST;
    end else if (!ce_s) begin
      // Chip enable low wipes every programmable register
      bit_cnt_q  <= 5'h00;
      shift_q    <= 16'h0000;
      tx_q       <= 8'h00;
      rd_phase_q <= 1'b0;
      dout_q     <= 1'b0;
      drive_q    <= 1'b0;
      ctrl_q     <= `SPC_CTRL_RST;
      power_q    <= `SPC_POWER_RST;
    end else if (sel_s) begin
      // Idle or burst over: drop any drive and restart framing
      bit_cnt_q  <= 5'h00;
      rd_phase_q <= 1'b0;
      drive_q    <= 1'b0;
      dout_q     <= 1'b0;
    end else if (sclk_rise) begin
      shift_q <= shift_d;
      if (bit_cnt_q != `SPC_FRAME_BITS) begin
        bit_cnt_q <= bit_cnt_d;
      end
      if (bit_cnt_d == {1'b0, `SPC_HDR_BITS} && shift_d[`SPC_RW_BIT]) begin
        rd_phase_q <= 1'b1;
        tx_q       <= rd_mux(shift_d[`SPC_ADDR_W-1:0], ctrl_q, power_q,
                             {4'h0, lock_q, out2_q, out1_q, active_q});
      end
      // Write commits on the last bit; power-down bit keeps contents
      if (bit_cnt_d == `SPC_FRAME_BITS && !frame_is_rd) begin
        case (frame_addr)
          `SPC_ADDR_CTRL:  ctrl_q  <= shift_d[`SPC_DATA_W-1:0];
          `SPC_ADDR_POWER: power_q <= shift_d[`SPC_DATA_W-1:0];
          default:         ctrl_q  <= ctrl_q;
        endcase
      end
    end else if (sclk_fall && rd_phase_q) begin
      // Read data changes on falling edges so the host samples on rising
      drive_q <= 1'b1;
      dout_q  <= tx_q[`SPC_DATA_W-1];
      tx_q    <= {tx_q[`SPC_DATA_W-2:0], 1'b0};
    end
  end

  // Power state and pin-level status
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_q <= 1'b0;
      out1_q   <= 1'b0;
      out2_q   <= 1'b0;
      lock_q   <= 1'b0;
    end else begin
      active_q <= run_gate(ce_s, pd_bit);
      out1_q   <= run_gate(ce_s, pd_bit) & pins_s[`SPC_LANE_EN1];
      out2_q   <= run_gate(ce_s, pd_bit) & pins_s[`SPC_LANE_EN2];
      lock_q   <= run_gate(ce_s, pd_bit) & pins_s[`SPC_LANE_LOCK];
    end
  end

  // Burst end releases both data pins in the same cycle
  assign sdio_out         = dout_q;
  assign sdio_oe_out      = drive_q & ~four_wire & ~burst_end & ~sel_s;
  assign read_data_out    = dout_q;
  assign read_data_oe_out = drive_q & four_wire & ~burst_end & ~sel_s;

  assign lock_indicator_out    = lock_q;
  assign device_active_out     = active_q;
  assign global_power_down_out = pd_bit;
  assign out1_active_out       = out1_q;
  assign out2_active_out       = out2_q;
  assign out1_power_out        = power_q[`SPC_PWR1_LSB +: `SPC_PWR_W];
  assign out2_power_out        = power_q[`SPC_PWR2_LSB +: `SPC_PWR_W];

endmodule // spc_pin_ctrl

`default_nettype wire

// ==== dv/spc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module spc_host_model (
  input  wire logic       clk_in,
  input  wire logic       dev_oe_in,
  input  wire logic       dev_bit_in,
  output var  logic       select_n_out,
  output var  logic       sclk_out,
  output wire logic       line_out,
  output var  logic       rd_valid_out,
  output var  logic [7:0] rd_data_out
);
  logic drv_q = 1'b0;
  logic bit_q = 1'b0;
  logic float_q = 1'b0;
  // A released line toggles each cycle; bit samples lie 8 cycles apart, so a missing drive reads as a constant 8'h00 or 8'hFF
  always @(negedge clk_in) float_q <= ~float_q;
  assign line_out = dev_oe_in ? dev_bit_in : (drv_q ? bit_q : float_q);
  initial begin
    select_n_out = 1'b1;
    sclk_out = 1'b0;
    rd_valid_out = 1'b0;
    rd_data_out = 8'h00;
  end
  task automatic xfer(input logic [15:0] frame);
    integer i;
    @(negedge clk_in);
    select_n_out = 1'b0;
    repeat (8) @(negedge clk_in);
    for (i = 15; i >= 0; i--) begin
      sclk_out = 1'b0;
      drv_q = !frame[15] || i > 7;
      bit_q = frame[i];
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      rd_data_out[i%8] = line_out;
      repeat (4) @(negedge clk_in);
    end
    select_n_out = 1'b1;
    sclk_out = 1'b0;
    drv_q = 1'b0;
    rd_valid_out = frame[15];
    @(negedge clk_in);
    rd_valid_out = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
endmodule // spc_host_model
`default_nettype wire

// ==== dv/spc_pin_ctrl_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module spc_pin_ctrl_chk (
  input wire logic       core_clk_in,
  input wire logic       resetn_in,
  input wire logic       chip_enable_in,
  input wire logic       out1_buffer_enable_in,
  input wire logic       out2_buffer_enable_in,
  input wire logic       pll_locked_in,
  input wire logic       select_n_in,
  input wire logic       sdio_oe_out,
  input wire logic       read_data_oe_out,
  input wire logic       lock_indicator_out,
  input wire logic       device_active_out,
  input wire logic       global_power_down_out,
  input wire logic       out1_active_out,
  input wire logic       out2_active_out,
  input wire logic [3:0] out1_power_out,
  input wire logic [3:0] out2_power_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  lock_rise_a: assert property ($rose(lock_indicator_out) |-> $past(pll_locked_in, 3))
    else $error("lock rose without loop lock");
  lock_low_a: assert property (!pll_locked_in [*5] |-> !lock_indicator_out)
    else $error("lock high while unlocked");
  out2_follow_a: assert property (out2_active_out |-> $past(out2_buffer_enable_in, 3))
    else $error("output 2 on while disabled");
  out1_follow_a: assert property (out1_active_out |-> $past(out1_buffer_enable_in, 3))
    else $error("output 1 on while disabled");
  ce_wake_a: assert property (chip_enable_in [*8] ##0 $past(!global_power_down_out)
    |-> device_active_out) else $error("not active with chip enable");
  ce_reset_a: assert property (!chip_enable_in [*5] |-> !device_active_out &&
    !global_power_down_out && out1_power_out == 4'hF && out2_power_out == 4'hF)
    else $error("chip enable low did not reset");
  pd_off_a: assert property (global_power_down_out [*2] |-> !device_active_out)
    else $error("active during power down");
  oe_single_a: assert property (!(sdio_oe_out && read_data_oe_out))
    else $error("both data outputs driven");
  oe_release_a: assert property (select_n_in [*4] |-> !sdio_oe_out && !read_data_oe_out)
    else $error("data drive kept after select high");
  pwr_write_a: assert property ($changed(out1_power_out) |-> !$past(select_n_in, 3) ||
    !$past(chip_enable_in, 2)) else $error("power changed outside burst");
  out1_on_a: assert property (device_active_out && $past(out1_buffer_enable_in, 3)
    |-> out1_active_out) else $error("output 1 off while enabled");
  out2_on_a: assert property (device_active_out && $past(out2_buffer_enable_in, 3)
    |-> out2_active_out) else $error("output 2 off while enabled");
  lock_on_a: assert property (device_active_out && $past(pll_locked_in, 3)
    |-> lock_indicator_out) else $error("lock low while loop locked");
endmodule // spc_pin_ctrl_chk
bind spc_pin_ctrl spc_pin_ctrl_chk chk_u (.*);
`default_nettype wire

// ==== dv/spc_pin_ctrl_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module spc_pin_ctrl_tb_top;
  logic core_clk_in = 0, resetn_in = 0, chip_enable_in = 0, pll_locked_in = 0;
  logic out1_buffer_enable_in = 0, out2_buffer_enable_in = 0;
  wire  select_n_in, sclk_in, sdio_in, sdio_out, sdio_oe_out, read_data_out, read_data_oe_out;
  wire  lock_indicator_out, device_active_out, global_power_down_out, rd_valid;
  wire  out1_active_out, out2_active_out;
  wire  [3:0] out1_power_out, out2_power_out;
  wire  [7:0] rd_data;
  logic [7:0] pw, q[$];
  integer fail_count = 0, cmp_count = 0, seed = 34, i;
  integer n3 = 0, n4 = 0;
  logic mode_4w = 0;
  spc_pin_ctrl dut_u (.*);
  spc_host_model host_u (.clk_in(core_clk_in), .dev_oe_in(sdio_oe_out | read_data_oe_out),
    .dev_bit_in(sdio_oe_out ? sdio_out : read_data_out), .select_n_out(select_n_in),
    .sclk_out(sclk_in), .line_out(sdio_in), .rd_valid_out(rd_valid), .rd_data_out(rd_data));
  initial forever #20 core_clk_in = ~core_clk_in;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    integer b3, b4;
    b3 = n3;
    b4 = n4;
    q.push_back(e);
    host_u.xfer({1'b1, a, 8'h00});
    cmp({6'h00, n4 != b4, n3 != b3}, {6'h00, mode_4w, !mode_4w});
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer({1'b0, a, d});
  endtask
  task tally_and_finish;
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk_in) if (rd_valid === 1'b1) cmp(rd_data, q.pop_front());
  // Counts cycles in which each data pin is driven, away from the launching edge
  always @(negedge core_clk_in) begin
    if (sdio_oe_out === 1'b1) n3++;
    if (read_data_oe_out === 1'b1) n4++;
  end
  initial begin
    #2000000 fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(negedge core_clk_in);
    resetn_in = 1;
    chip_enable_in = 1;
    repeat (8) @(negedge core_clk_in);
    rd(7'h00, 8'h00);
    rd(7'h01, 8'hFF);
    rd(7'h7F, 8'h00);
    pw = 8'($random(seed));
    wr(7'h01, pw);
    rd(7'h01, pw);
    cmp({out2_power_out, out1_power_out}, pw);
    for (i = 0; i < 4; i++) begin
      {pll_locked_in, out2_buffer_enable_in, out1_buffer_enable_in} = 3'($random(seed));
      repeat (8) @(negedge core_clk_in);
      rd(7'h02, {4'h0, pll_locked_in, out2_buffer_enable_in, out1_buffer_enable_in, 1'b1});
    end
    wr(7'h00, 8'h03);
    mode_4w = 1'b1;
    cmp({6'h00, global_power_down_out, device_active_out}, 8'h02);
    rd(7'h00, 8'h03);
    rd(7'h01, pw);
    rd(7'h02, 8'h00);
    chip_enable_in = 0;
    mode_4w = 1'b0;
    repeat (8) @(negedge core_clk_in);
    chip_enable_in = 1;
    repeat (8) @(negedge core_clk_in);
    cmp({6'h00, global_power_down_out, device_active_out}, 8'h01);
    rd(7'h00, 8'h00);
    rd(7'h01, 8'hFF);
    wr(7'h01, ~pw);
    cmp({out2_power_out, out1_power_out}, ~pw);
    resetn_in = 0;
    repeat (4) @(negedge core_clk_in);
    resetn_in = 1;
    repeat (8) @(negedge core_clk_in);
    rd(7'h01, 8'hFF);
    cmp(8'(q.size()), 8'h00);
    tally_and_finish;
  end
endmodule // spc_pin_ctrl_tb_top
`default_nettype wire
